/* inc/dpc_defines.vh */
// Register offsets, field positions, reset values and timing counts for the playback path control
// Overview of operation
// - With the mono bit set, left and right samples are summed, halved and sent to both outputs.
// - The frame ratio bit selects a system clock of 256 times the sample rate when 0, 272 when 1.
// - De-emphasis code 0 disables the filter; codes 1, 2 and 3 select 32kHz, 44.1kHz and 48kHz.
// - The modulator over-rate bit runs the modulator faster than its normal 64 times fs.
// - Each channel has a polarity bit; 1 inverts its samples and 0 passes them unchanged.
// - Volume writes are staged; both channels take them together when a 1 goes to either commit bit.
// - Volume code 0 is mute, code 1 is -71.625dB, each step adds 0.375dB and 0xC0 (reset) is 0dB.
// - In master mode the frame clock generator runs only while its enable bit is 1.
// - An eleven-bit field sets bit clocks per frame clock phase from 8 to 2047, reset 64.
// - A three-bit divider gives sample clock ratios 1, 1.5, 2, 3, 4, 5.5 and 6; code 7 is reserved.
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

`define DPC_ADDR_W 8
`define DPC_OFF_CONTROL 8'h30
`define DPC_OFF_VOL_LEFT 8'h32
`define DPC_OFF_VOL_RIGHT 8'h33
`define DPC_OFF_FRAME_RATE 8'h35
`define DPC_OFF_CLOCK_CTRL 8'h36

`define DPC_BIT_MONO 13
`define DPC_BIT_RATIO 12
`define DPC_DEEMPHASIS_SELECT_HI 5
`define DPC_DEEMPHASIS_SELECT_LO 4
`define DPC_BIT_OVERRATE 3
`define DPC_BIT_LINV 1
`define DPC_BIT_RINV 0

`define DPC_BIT_CH_ENABLE 15
`define DPC_BIT_COMMIT 8
`define DPC_VOL_HI 7

`define DPC_BIT_FRAME_EN 11
`define DPC_RATE_HI 10

`define DPC_BIT_CLK_INV 4
`define DPC_DIV_HI 2

`define DPC_VOL_RESET 8'hC0
`define DPC_RATE_RESET 11'h040
`define DPC_RATE_MIN 11'h008
`define DPC_DIV_RESERVED 3'h7

// Modulator oversampling in system clocks per sample
`define DPC_SDM_NORMAL 9'h040
`define DPC_SDM_FAST 9'h080

// System clocks per sample for the two frame ratio settings
`define DPC_RATIO_NORMAL 9'h100
`define DPC_RATIO_ALT 9'h110

`endif

/* design/dpc_playback_control.v */
// Playback digital path control registers with sample path, frame clock and rate divider
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "dpc_defines.vh"

module dpc_playback_control (
  // Clock, reset, enable
  input wire core_clk_i,
  input wire reset_n_i,
  input wire clk_en_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // Sample path, same clock domain
  input wire sample_valid_i,
  input wire [15:0] left_sample_i,
  input wire [15:0] right_sample_i,
  output reg sample_valid_o,
  output reg [15:0] left_sample_o,
  output reg [15:0] right_sample_o,
  // Active volume and filter controls to the converter
  output reg [7:0] left_volume_o,
  output reg [7:0] right_volume_o,
  output reg left_mute_o,
  output reg right_mute_o,
  output reg [1:0] deemphasis_select_o,
  output reg deemph_32k_o,
  output reg deemph_44k1_o,
  output reg deemph_48k_o,
  output reg [8:0] system_clock_ratio_o,
  output reg [8:0] modulator_clocks_o,
  // Frame clock (master mode)
  input wire master_mode_i,
  input wire bit_clock_tick_i,
  output reg frame_clock_o,
  // Sample clock divider and converter clock
  output reg sample_clock_tick_o,
  output reg converter_clock_o,
  output reg divider_reserved_o
);

  // Control registers
  reg mono;
  reg frame_ratio_select;
  reg [1:0] deemphasis_select;
  reg modulator_overrate;
  reg left_polarity_invert;
  reg right_polarity_invert;
  reg left_channel_enable;
  reg right_channel_enable;
  reg [7:0] left_volume;
  reg [7:0] right_volume;
  reg [7:0] left_volume_act;
  reg [7:0] right_volume_act;
  reg frame_clock_gen_enable;
  reg [10:0] bit_clocks_per_phase;
  reg converter_clock_invert;
  reg [2:0] sample_clock_divider;

  // Pin input synchroniser for the bit clock tick, then frame counter, divider and converter clock state
  reg bclk_meta;
  reg bclk_sync;
  reg bclk_last;
  reg [10:0] phase_count;
  reg [3:0] div_count;
  reg half_toggle;
  reg conv_clk;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == `DPC_OFF_CONTROL);
  wire wr_voll = reg_wr_i && (reg_addr_i == `DPC_OFF_VOL_LEFT);
  wire wr_volr = reg_wr_i && (reg_addr_i == `DPC_OFF_VOL_RIGHT);
  wire wr_rate = reg_wr_i && (reg_addr_i == `DPC_OFF_FRAME_RATE);
  wire wr_clk = reg_wr_i && (reg_addr_i == `DPC_OFF_CLOCK_CTRL);
  wire commit = (wr_voll || wr_volr) && reg_wdata_i[`DPC_BIT_COMMIT];

  // Register writes
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mono <= 1'b0;
      frame_ratio_select <= 1'b0;
      deemphasis_select <= 2'h0;
      modulator_overrate <= 1'b0;
      left_polarity_invert <= 1'b0;
      right_polarity_invert <= 1'b0;
      left_channel_enable <= 1'b0;
      right_channel_enable <= 1'b0;
      left_volume <= `DPC_VOL_RESET;
      right_volume <= `DPC_VOL_RESET;
      left_volume_act <= `DPC_VOL_RESET;
      right_volume_act <= `DPC_VOL_RESET;
      frame_clock_gen_enable <= 1'b0;
      bit_clocks_per_phase <= `DPC_RATE_RESET;
      converter_clock_invert <= 1'b0;
      sample_clock_divider <= 3'h0;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        mono <= reg_wdata_i[`DPC_BIT_MONO];
        frame_ratio_select <= reg_wdata_i[`DPC_BIT_RATIO];
        deemphasis_select <= reg_wdata_i[`DPC_DEEMPHASIS_SELECT_HI:`DPC_DEEMPHASIS_SELECT_LO];
        modulator_overrate <= reg_wdata_i[`DPC_BIT_OVERRATE];
        left_polarity_invert <= reg_wdata_i[`DPC_BIT_LINV];
        right_polarity_invert <= reg_wdata_i[`DPC_BIT_RINV];
      end
      if (wr_voll) begin
        left_channel_enable <= reg_wdata_i[`DPC_BIT_CH_ENABLE];
        left_volume <= reg_wdata_i[`DPC_VOL_HI:0];
      end
      if (wr_volr) begin
        right_channel_enable <= reg_wdata_i[`DPC_BIT_CH_ENABLE];
        right_volume <= reg_wdata_i[`DPC_VOL_HI:0];
      end
      // staged commit, takes the value written in the same cycle
      if (commit) begin
        left_volume_act <= wr_voll ? reg_wdata_i[`DPC_VOL_HI:0] : left_volume;
        right_volume_act <= wr_volr ? reg_wdata_i[`DPC_VOL_HI:0] : right_volume;
      end
      if (wr_rate) begin
        frame_clock_gen_enable <= reg_wdata_i[`DPC_BIT_FRAME_EN];
        bit_clocks_per_phase <= reg_wdata_i[`DPC_RATE_HI:0];
      end
      if (wr_clk) begin
        converter_clock_invert <= reg_wdata_i[`DPC_BIT_CLK_INV];
        sample_clock_divider <= reg_wdata_i[`DPC_DIV_HI:0];
      end
    end
  end

  // Read data; commit bit is write-only and reads 0
  reg [15:0] next_rdata;
  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr_i)
      `DPC_OFF_CONTROL: begin
        next_rdata[`DPC_BIT_MONO] = mono;
        next_rdata[`DPC_BIT_RATIO] = frame_ratio_select;
        next_rdata[`DPC_DEEMPHASIS_SELECT_HI:`DPC_DEEMPHASIS_SELECT_LO] = deemphasis_select;
        next_rdata[`DPC_BIT_OVERRATE] = modulator_overrate;
        next_rdata[`DPC_BIT_LINV] = left_polarity_invert;
        next_rdata[`DPC_BIT_RINV] = right_polarity_invert;
      end
      `DPC_OFF_VOL_LEFT: begin
        next_rdata[`DPC_BIT_CH_ENABLE] = left_channel_enable;
        next_rdata[`DPC_VOL_HI:0] = left_volume;
      end
      `DPC_OFF_VOL_RIGHT: begin
        next_rdata[`DPC_BIT_CH_ENABLE] = right_channel_enable;
        next_rdata[`DPC_VOL_HI:0] = right_volume;
      end
      `DPC_OFF_FRAME_RATE: begin
        next_rdata[`DPC_BIT_FRAME_EN] = frame_clock_gen_enable;
        next_rdata[`DPC_RATE_HI:0] = bit_clocks_per_phase;
      end
      `DPC_OFF_CLOCK_CTRL: begin
        next_rdata[`DPC_BIT_CLK_INV] = converter_clock_invert;
        next_rdata[`DPC_DIV_HI:0] = sample_clock_divider;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Sample path
  wire [16:0] mono_sum = {left_sample_i[15], left_sample_i} + {right_sample_i[15], right_sample_i};
  wire [15:0] mono_half = mono_sum[16:1];
  // Channel 1 is left and channel 0 is right throughout these vectors
  wire [31:0] ch_in = {left_sample_i, right_sample_i};
  wire [1:0] ch_invert = {left_polarity_invert, right_polarity_invert};
  wire [1:0] ch_enable = {left_channel_enable, right_channel_enable};
  wire [31:0] ch_out;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire [15:0] mixed = mono ? mono_half : ch_in[16*ch +: 16];
      wire [15:0] signed_out = ch_invert[ch] ? (16'h0000 - mixed) : mixed;
      assign ch_out[16*ch +: 16] = ch_enable[ch] ? signed_out : 16'h0000;
    end
  endgenerate

  // Sample clock divider: counts half system clocks so 1.5 and 5.5 come out exact on average
  reg [3:0] div_half;
  always @* begin
    case (sample_clock_divider)
      3'h0: div_half = 4'h2;
      3'h1: div_half = 4'h3;
      3'h2: div_half = 4'h4;
      3'h3: div_half = 4'h6;
      3'h4: div_half = 4'h8;
      3'h5: div_half = 4'hB;
      3'h6: div_half = 4'hC;
      default: div_half = 4'h2;
    endcase
  end

  wire [4:0] div_next = {1'b0, div_count} + 5'h02;
  wire rate_ok = bit_clocks_per_phase >= `DPC_RATE_MIN;
  wire frame_run = master_mode_i && frame_clock_gen_enable && rate_ok;

  // Register read data, zero outside the cycle after a read strobe
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (clk_en_i) begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 16'h0000;
    end
  end

  // Processed samples; outputs hold their last value between strobes
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_valid_o <= 1'b0;
      left_sample_o <= 16'h0000;
      right_sample_o <= 16'h0000;
    end else if (clk_en_i) begin
      sample_valid_o <= sample_valid_i;
      if (sample_valid_i) begin
        left_sample_o <= ch_out[31:16];
        right_sample_o <= ch_out[15:0];
      end
    end
  end

  // Active volume to the converter
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      left_volume_o <= `DPC_VOL_RESET;
      right_volume_o <= `DPC_VOL_RESET;
      left_mute_o <= 1'b0;
      right_mute_o <= 1'b0;
    end else if (clk_en_i) begin
      // active codes; code 0 is digital mute
      left_volume_o <= left_volume_act;
      right_volume_o <= right_volume_act;
      left_mute_o <= (left_volume_act == 8'h00);
      right_mute_o <= (right_volume_act == 8'h00);
    end
  end

  // Filter and clock rate decodes
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      deemphasis_select_o <= 2'h0;
      deemph_32k_o <= 1'b0;
      deemph_44k1_o <= 1'b0;
      deemph_48k_o <= 1'b0;
      system_clock_ratio_o <= `DPC_RATIO_NORMAL;
      modulator_clocks_o <= `DPC_SDM_NORMAL;
    end else if (clk_en_i) begin
      deemphasis_select_o <= deemphasis_select;
      deemph_32k_o <= (deemphasis_select == 2'h1);
      deemph_44k1_o <= (deemphasis_select == 2'h2);
      deemph_48k_o <= (deemphasis_select == 2'h3);
      system_clock_ratio_o <= frame_ratio_select ? `DPC_RATIO_ALT : `DPC_RATIO_NORMAL;
      modulator_clocks_o <= modulator_overrate ? `DPC_SDM_FAST : `DPC_SDM_NORMAL;
    end
  end

  // Frame clock generator; the bit clock tick is a pin, so only its synchronised copy is read
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bclk_meta <= 1'b0;
      bclk_sync <= 1'b0;
      bclk_last <= 1'b0;
      phase_count <= 11'h000;
      frame_clock_o <= 1'b0;
    end else if (clk_en_i) begin
      bclk_meta <= bit_clock_tick_i;
      bclk_sync <= bclk_meta;
      bclk_last <= bclk_sync;
      // generator held idle unless enabled in master mode with at least 8 bit clocks per phase
      if (!frame_run) begin
        phase_count <= 11'h000;
        frame_clock_o <= 1'b0;
      end else if (bclk_sync && !bclk_last) begin
        // toggle after the programmed number of bit clocks
        if (phase_count >= bit_clocks_per_phase - 11'h001) begin
          phase_count <= 11'h000;
          frame_clock_o <= ~frame_clock_o;
        end else begin
          phase_count <= phase_count + 11'h001;
        end
      end
    end
  end

  // Sample clock divider
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_count <= 4'h0;
      sample_clock_tick_o <= 1'b0;
      divider_reserved_o <= 1'b0;
    end else if (clk_en_i) begin
      // fractional divider, reserved code halts the tick
      divider_reserved_o <= (sample_clock_divider == `DPC_DIV_RESERVED);
      if (sample_clock_divider == `DPC_DIV_RESERVED) begin
        div_count <= 4'h0;
        sample_clock_tick_o <= 1'b0;
      end else if (div_next[4:0] >= {1'b0, div_half}) begin
        div_count <= div_next[3:0] - div_half;
        sample_clock_tick_o <= 1'b1;
      end else begin
        div_count <= div_next[3:0];
        sample_clock_tick_o <= 1'b0;
      end
    end
  end

  // Converter clock; retimed once more so the polarity swap cannot glitch the output
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      half_toggle <= 1'b0;
      conv_clk <= 1'b0;
      converter_clock_o <= 1'b0;
    end else if (clk_en_i) begin
      if (sample_clock_tick_o) begin
        half_toggle <= ~half_toggle;
      end
      conv_clk <= half_toggle;
      converter_clock_o <= converter_clock_invert ? ~conv_clk : conv_clk;
    end
  end

endmodule

/* tb/dpc_playback_control_props.sv */
// Assertion checker for the playback path control block
`timescale 1ns/100ps
module dpc_playback_control_props (
  // Clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // Watched ports
  input wire clk_en_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire sample_valid_i,
  input wire sample_valid_o,
  input wire [7:0] left_volume_o,
  input wire [7:0] right_volume_o,
  input wire deemph_32k_o,
  input wire deemph_44k1_o,
  input wire deemph_48k_o,
  input wire [8:0] system_clock_ratio_o,
  input wire [8:0] modulator_clocks_o,
  input wire master_mode_i,
  input wire frame_clock_o,
  input wire sample_clock_tick_o,
  input wire divider_reserved_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire vol_addr = (reg_addr_i == 8'h32) || (reg_addr_i == 8'h33);
  wire commit_wr = reg_wr_i && clk_en_i && reg_wdata_i[8] && vol_addr;
  property p_vol_staged;
    $changed(left_volume_o) || $changed(right_volume_o) |-> $past(commit_wr, 2);
  endproperty
  a_vol_staged: assert property (p_vol_staged) else $error("volume moved without commit");
  property p_valid_out;
    sample_valid_i && clk_en_i |=> sample_valid_o;
  endproperty
  a_valid_out: assert property (p_valid_out) else $error("sample not passed on");
  property p_valid_idle;
    !sample_valid_i && clk_en_i |=> !sample_valid_o;
  endproperty
  a_valid_idle: assert property (p_valid_idle) else $error("spurious sample");
  property p_rdata_idle;
    clk_en_i && !reg_rd_i |=> reg_rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  property p_ratio;
    system_clock_ratio_o == 9'h100 || system_clock_ratio_o == 9'h110;
  endproperty
  a_ratio: assert property (p_ratio) else $error("bad clock ratio");
  property p_mod;
    modulator_clocks_o == 9'h040 || modulator_clocks_o == 9'h080;
  endproperty
  a_mod: assert property (p_mod) else $error("bad modulator rate");
  property p_deemph;
    $onehot0({deemph_32k_o, deemph_44k1_o, deemph_48k_o});
  endproperty
  a_deemph: assert property (p_deemph) else $error("two filters selected");
  property p_frame_slave;
    !master_mode_i [*2] |-> !frame_clock_o;
  endproperty
  a_frame_slave: assert property (p_frame_slave) else $error("frame clock in slave");
  property p_reserved;
    divider_reserved_o [*2] |-> !sample_clock_tick_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("tick on reserved code");
endmodule
bind dpc_playback_control dpc_playback_control_props dpc_playback_control_props_inst (.*);

/* tb/dpc_playback_control_tb.sv */
// Self-checking bench for the playback path control block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module dpc_playback_control_tb;
  reg core_clk_i = 0, reset_n_i = 0, clk_en_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  reg sample_valid_i = 0, master_mode_i = 0, bit_clock_tick_i = 0, rd_seen = 0;
  reg [7:0] reg_addr_i = 0;
  reg [15:0] reg_wdata_i = 0, left_sample_i = 0, right_sample_i = 0;
  wire [15:0] reg_rdata_o, left_sample_o, right_sample_o;
  wire [7:0] left_volume_o, right_volume_o;
  wire [8:0] system_clock_ratio_o, modulator_clocks_o;
  wire [1:0] deemphasis_select_o;
  wire sample_valid_o, left_mute_o, right_mute_o, deemph_32k_o, deemph_44k1_o;
  wire deemph_48k_o, frame_clock_o, sample_clock_tick_o, converter_clock_o;
  wire divider_reserved_o;
  int fails = 0;
  int n_tests = 0;
  int nt[8] = '{66, 44, 33, 22, 16, 12, 11, 0};
  logic [15:0] rq[$];
  logic [31:0] sq[$];
  dpc_playback_control dpc_playback_control_inst (.*);
  always #4 core_clk_i = ~core_clk_i;
  // Results are taken off the queues in the order they were requested
  always @(posedge core_clk_i) begin
    if (reset_n_i) begin
      if (rd_seen) `CHK(reg_rdata_o, rq.pop_front())
      else `CHK(reg_rdata_o, 16'h0000)
      if (sample_valid_o) `CHK({left_sample_o, right_sample_o}, sq.pop_front())
    end
    rd_seen <= reg_rd_i && clk_en_i;
  end
  task cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    rq.push_back(e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task snd(input [15:0] l, input [15:0] r, input [31:0] e);
    @(posedge core_clk_i);
    left_sample_i <= l;
    right_sample_i <= r;
    sample_valid_i <= 1'b1;
    sq.push_back(e);
    @(posedge core_clk_i);
    sample_valid_i <= 1'b0;
  endtask
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #700000;
    fails++;
    report_and_stop;
  end
  initial begin
    int i, k, c, t;
    logic f, v;
    logic [15:0] d, l, r, ml, mr;
    logic [16:0] s;
    void'($urandom(32'h6557));
    cyc(3);
    reset_n_i <= 1'b1;
    rd(8'h30, 0);
    rd(8'h32, 16'h00C0);
    rd(8'h33, 16'h00C0);
    rd(8'h35, 16'h0040);
    rd(8'h36, 0);
    rd(8'h31, 0);
    `CHK({left_volume_o, right_volume_o}, 16'hC0C0)
    for (i = 0; i < 4; i++) begin
      d = ($urandom & 16'hFFCF) | (i << 4);
      wr(8'h30, d);
      rd(8'h30, d & 16'h303B);
      cyc(2);
      `CHK({deemph_48k_o, deemph_44k1_o, deemph_32k_o}, (4'h1 << i) >> 1)
      `CHK(deemphasis_select_o, i[1:0])
      `CHK(system_clock_ratio_o, d[12] ? 9'h110 : 9'h100)
      `CHK(modulator_clocks_o, d[3] ? 9'h080 : 9'h040)
    end
    clk_en_i <= 1'b0;
    wr(8'h30, 16'h0000);
    clk_en_i <= 1'b1;
    rd(8'h30, d & 16'h303B);
    wr(8'h32, 16'h8055);
    wr(8'h33, 16'h8033);
    cyc(3);
    `CHK({left_volume_o, right_volume_o}, 16'hC0C0)
    wr(8'h33, 16'h8123);
    cyc(3);
    `CHK({left_volume_o, right_volume_o}, 16'h5523)
    rd(8'h32, 16'h8055);
    wr(8'h32, 16'h8100);
    cyc(3);
    `CHK({left_mute_o, right_mute_o}, 2'b10)
    for (i = 0; i < 8; i++) begin
      d = $urandom & 16'h2003;
      wr(8'h30, d);
      l = $urandom;
      r = $urandom;
      s = {l[15], l} + {r[15], r};
      ml = d[13] ? s[16:1] : l;
      mr = d[13] ? s[16:1] : r;
      snd(l, r, {d[1] ? -ml : ml, d[0] ? -mr : mr});
    end
    wr(8'h30, 0);
    wr(8'h33, 16'h0023);
    snd(16'h1234, 16'h5678, {16'h1234, 16'h0000});
    master_mode_i <= 1'b1;
    for (k = 0; k < 3; k++) begin
      wr(8'h35, k == 0 ? 16'h0807 : k == 1 ? 16'h0008 : 16'h0808);
      c = 0;
      t = 0;
      f = frame_clock_o;
      repeat (264) begin
        @(posedge core_clk_i);
        bit_clock_tick_i <= t[1];
        t++;
        c += frame_clock_o ^ f;
        f = frame_clock_o;
      end
      `CHK(c, k == 2 ? 8 : 0)
    end
    rd(8'h35, 16'h0808);
    for (k = 0; k < 8; k++) begin
      wr(8'h36, k);
      cyc(4);
      c = 0;
      repeat (66) begin
        @(posedge core_clk_i);
        c += sample_clock_tick_o;
      end
      `CHK(c >= nt[k] - 1 && c <= nt[k] + 1, 1'b1)
      `CHK(divider_reserved_o, k == 7)
    end
    wr(8'h36, 16'h0017);
    rd(8'h36, 16'h0017);
    cyc(2);
    v = converter_clock_o;
    wr(8'h36, 16'h0007);
    cyc(3);
    `CHK(converter_clock_o, ~v)
    cyc(2);
    report_and_stop;
  end
endmodule
